// file: pkg/psc_pkg.sv
package psc_pkg;
   // Power state of the whole device
   typedef enum logic [1:0] {
      PSC_OFF,
      PSC_ACTIVE,
      PSC_SLEEP
   } psc_pstate_e;

   // Transition sequence identifiers, also the slot index in the OTP table
   localparam logic [2:0] SEQ_OFF_TO_ACTIVE = 3'h0;
   localparam logic [2:0] SEQ_ACTIVE_TO_OFF = 3'h1;
   localparam logic [2:0] SEQ_SLEEP_TO_OFF = 3'h2;
   localparam logic [2:0] SEQ_ACTIVE_TO_SLEEP = 3'h3;
   localparam logic [2:0] SEQ_SLEEP_TO_ACTIVE = 3'h4;
   localparam int NUM_SEQ = 5;

   // Request bit positions on req_i
   localparam int REQ_ON = 0;
   localparam int REQ_OFF = 1;
   localparam int REQ_WAKE = 2;
   localparam int REQ_SLEEP = 3;

   // One sequence step: {delay, vcode, enable, resource, valid}
   localparam int STEP_VALID = 0;
   localparam int STEP_RES = 1;
   localparam int STEP_RES_W = 5;
   localparam int STEP_EN = 6;
   localparam int STEP_VCODE = 7;
   localparam int STEP_DELAY = 15;
   localparam int STEP_DELAY_W = 4;
   localparam int STEP_W = 19;

   // Resource indices with special roles
   localparam logic [4:0] RES_DUAL_PHASE_RAIL_A = 5'h00;
   localparam logic [4:0] RES_SINGLE_PHASE_RAIL_A = 5'h01;
   localparam logic [4:0] RES_DUAL_PHASE_RAIL_B = 5'h02;
   localparam logic [4:0] RES_SINGLE_PHASE_RAIL_B = 5'h03;
   localparam logic [4:0] RES_MID_CURRENT_RAIL = 5'h04;
   localparam logic [4:0] RES_LOW_CURRENT_RAIL = 5'h05;
   localparam int NUM_SWITCHERS = 7;

   // Switcher voltage code layout: bit 7 range select, bits 6:0 step
   localparam int VCODE_RANGE = 7;
   localparam logic [6:0] SWITCHER_STEP_MAX = 7'h73;
   localparam logic [7:0] LINEAR_CODE_MAX = 8'h31;

   // Reset values
   localparam logic [7:0] VCODE_RST = 8'h00;
endpackage

// file: src/psc_power_state_controller.sv
`timescale 1ns/1ps
`default_nettype none
module psc_power_state_controller #(
   parameter int NUM_RES = 22,
   parameter int STEPS = 8
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Power requests and pins, asynchronous
   input wire logic [3:0] req_i,
   input wire logic osc32k_i,
   input wire logic sleep_request_pin_n_i,
   input wire logic first_enable_pin_i,
   input wire logic roof_floor_i,
   // OTP configuration, static
   input wire logic [NUM_RES-1:0] otp_def_en_i,
   input wire logic [NUM_RES*8-1:0] otp_def_vcode_i,
   input wire logic [psc_pkg::NUM_SEQ*STEPS*psc_pkg::STEP_W-1:0] otp_seq_i,
   input wire logic [NUM_RES-1:0] otp_sleep_map_i,
   input wire logic [NUM_RES-1:0] otp_en1_map_i,
   input wire logic [NUM_RES-1:0] otp_rf_map_i,
   input wire logic merge_a_i,
   input wire logic merge_b_i,
   // Host register port, same clock
   input wire logic host_wr_i,
   input wire logic [4:0] host_res_i,
   input wire logic host_en_i,
   input wire logic [7:0] host_vcode_i,
   input wire logic [7:0] roof_vcode_i,
   input wire logic [7:0] floor_vcode_i,
   // Dedicated DVS port, same clock
   input wire logic dvs_wr_i,
   input wire logic [1:0] dvs_sel_i,
   input wire logic [7:0] dvs_vcode_i,
   // Resource outputs
   output logic [NUM_RES-1:0] rail_on_o,
   output logic [NUM_RES*8-1:0] rail_vcode_o,
   output logic [3:0] ext_en_o,
   // Status
   output logic [1:0] power_state_o,
   output logic seq_busy_o,
   output logic [NUM_RES-1:0] host_rd_en_o,
   output logic [NUM_RES*8-1:0] host_rd_vcode_o
);
   typedef enum logic [1:0] {
      FSM_BOOT,
      FSM_IDLE,
      FSM_RUN,
      FSM_WAIT
   } psc_fsm_e;

   typedef struct packed {
      psc_fsm_e fsm;
      psc_pkg::psc_pstate_e pstate;
      logic [2:0] seq;
      logic [$clog2(STEPS+1)-1:0] step;
      logic [psc_pkg::STEP_DELAY_W-1:0] wait_cnt;
      logic [3:0] pend;
      logic [3:0] req_s1;
      logic [3:0] req_s2;
      logic [3:0] req_prev;
      logic [2:0] osc_sync;
      logic [1:0] slp_sync;
      logic [1:0] en1_sync;
      logic [2:0] rf_sync;
      logic [NUM_RES-1:0] en;
      logic [NUM_RES-1:0][7:0] vcode;
      logic [NUM_RES-1:0] on_out;
      logic [NUM_RES-1:0][7:0] vcode_out;
   } psc_state_s;

   psc_state_s s;
   psc_state_s next_s;

   // DVS selector to resource index
   function automatic logic [4:0] dvs_target(input logic [1:0] sel);
      case (sel)
         2'h0: dvs_target = psc_pkg::RES_DUAL_PHASE_RAIL_A;
         2'h1: dvs_target = psc_pkg::RES_DUAL_PHASE_RAIL_B;
         2'h2: dvs_target = psc_pkg::RES_MID_CURRENT_RAIL;
         default: dvs_target = psc_pkg::RES_LOW_CURRENT_RAIL;
      endcase
   endfunction

   // Clamp a code into the legal span of its resource type
   function automatic logic [7:0] legal_code(input logic [4:0] res, input logic [7:0] code);
      if (int'(res) < psc_pkg::NUM_SWITCHERS) begin
         legal_code = code;
         if (code[6:0] > psc_pkg::SWITCHER_STEP_MAX) begin
            legal_code[6:0] = psc_pkg::SWITCHER_STEP_MAX;
         end
      end else if (code > psc_pkg::LINEAR_CODE_MAX) begin
         legal_code = psc_pkg::LINEAR_CODE_MAX;
      end else begin
         legal_code = code;
      end
   endfunction

   logic [psc_pkg::STEP_W-1:0] entry;
   logic tick;
   logic [3:0] edges;
   logic [3:0] legal;
   logic [4:0] ent_res;
   logic [4:0] dvs_res;

   assign tick = s.osc_sync[1] & ~s.osc_sync[2];
   assign edges = s.req_s2 & ~s.req_prev;
   assign entry = otp_seq_i[(int'(s.seq) * STEPS + int'(s.step)) * psc_pkg::STEP_W +:
      psc_pkg::STEP_W];
   assign ent_res = entry[psc_pkg::STEP_RES +: psc_pkg::STEP_RES_W];
   assign dvs_res = dvs_target(dvs_sel_i);

   // Requests that make sense in the present power state
   always_comb begin
      legal = 4'h0;
      case (s.pstate)
         psc_pkg::PSC_OFF: legal[psc_pkg::REQ_ON] = 1'b1;
         psc_pkg::PSC_ACTIVE: begin
            legal[psc_pkg::REQ_OFF] = 1'b1;
            legal[psc_pkg::REQ_SLEEP] = 1'b1;
         end
         psc_pkg::PSC_SLEEP: begin
            legal[psc_pkg::REQ_OFF] = 1'b1;
            legal[psc_pkg::REQ_WAKE] = 1'b1;
         end
         default: legal = 4'h0;
      endcase
   end

   // Next-state logic for the whole controller
   always_comb begin
      next_s = s;
      // Synchronisers; the second stage feeds logic, and a third stage feeds the edge detectors
      next_s.req_s1 = req_i;
      next_s.req_s2 = s.req_s1;
      next_s.req_prev = s.req_s2;
      next_s.osc_sync = {s.osc_sync[1:0], osc32k_i};
      next_s.slp_sync = {s.slp_sync[0], sleep_request_pin_n_i};
      next_s.en1_sync = {s.en1_sync[0], first_enable_pin_i};
      next_s.rf_sync = {s.rf_sync[1:0], roof_floor_i};
      // Requests latch until served, so none is lost mid-sequence
      next_s.pend = s.pend | edges;

      // Host writes first; a sequencer step in the same cycle wins
      if (host_wr_i && int'(host_res_i) < NUM_RES) begin
         next_s.en[host_res_i] = host_en_i;
         next_s.vcode[host_res_i] = legal_code(host_res_i, host_vcode_i);
      end
      if (dvs_wr_i) begin
         next_s.vcode[dvs_res] = legal_code(dvs_res, dvs_vcode_i);
      end
      // Roof/floor pin swaps mapped rails between two set points
      if (s.rf_sync[1] != s.rf_sync[2]) begin
         for (int i = 0; i < NUM_RES; i++) begin
            if (otp_rf_map_i[i]) begin
               next_s.vcode[i] = legal_code(5'(i),
                  s.rf_sync[1] ? roof_vcode_i : floor_vcode_i);
            end
         end
      end

      case (s.fsm)
         FSM_BOOT: begin
            // Defaults stay until something writes the resource
            next_s.en = otp_def_en_i;
            for (int i = 0; i < NUM_RES; i++) begin
               next_s.vcode[i] = otp_def_vcode_i[i*8 +: 8];
            end
            next_s.fsm = FSM_IDLE;
         end
         FSM_IDLE: begin
            next_s.step = '0;
            // Stale requests for the wrong state are dropped
            next_s.pend = (s.pend & legal) | edges;
            if (s.pend[psc_pkg::REQ_OFF] && legal[psc_pkg::REQ_OFF]) begin
               next_s.seq = (s.pstate == psc_pkg::PSC_SLEEP) ?
                  psc_pkg::SEQ_SLEEP_TO_OFF : psc_pkg::SEQ_ACTIVE_TO_OFF;
               next_s.pend[psc_pkg::REQ_OFF] = edges[psc_pkg::REQ_OFF];
               next_s.fsm = FSM_RUN;
            end else if (s.pend[psc_pkg::REQ_SLEEP] && legal[psc_pkg::REQ_SLEEP]) begin
               next_s.seq = psc_pkg::SEQ_ACTIVE_TO_SLEEP;
               next_s.pend[psc_pkg::REQ_SLEEP] = edges[psc_pkg::REQ_SLEEP];
               next_s.fsm = FSM_RUN;
            end else if (s.pend[psc_pkg::REQ_WAKE] && legal[psc_pkg::REQ_WAKE]) begin
               next_s.seq = psc_pkg::SEQ_SLEEP_TO_ACTIVE;
               next_s.pend[psc_pkg::REQ_WAKE] = edges[psc_pkg::REQ_WAKE];
               next_s.fsm = FSM_RUN;
            end else if (s.pend[psc_pkg::REQ_ON] && legal[psc_pkg::REQ_ON]) begin
               next_s.seq = psc_pkg::SEQ_OFF_TO_ACTIVE;
               next_s.pend[psc_pkg::REQ_ON] = edges[psc_pkg::REQ_ON];
               next_s.fsm = FSM_RUN;
            end
         end
         FSM_RUN: begin
            if (int'(s.step) >= STEPS || !entry[psc_pkg::STEP_VALID]) begin
               // End of table: commit the new power state
               case (s.seq)
                  psc_pkg::SEQ_OFF_TO_ACTIVE: next_s.pstate = psc_pkg::PSC_ACTIVE;
                  psc_pkg::SEQ_SLEEP_TO_ACTIVE: next_s.pstate = psc_pkg::PSC_ACTIVE;
                  psc_pkg::SEQ_ACTIVE_TO_SLEEP: next_s.pstate = psc_pkg::PSC_SLEEP;
                  default: next_s.pstate = psc_pkg::PSC_OFF;
               endcase
               next_s.fsm = FSM_IDLE;
            end else begin
               // A step is a register write to any resource plus a delay count
               if (int'(ent_res) < NUM_RES) begin
                  next_s.en[ent_res] = entry[psc_pkg::STEP_EN];
                  next_s.vcode[ent_res] = legal_code(ent_res,
                     entry[psc_pkg::STEP_VCODE +: 8]);
               end
               next_s.wait_cnt = entry[psc_pkg::STEP_DELAY +: psc_pkg::STEP_DELAY_W];
               if (entry[psc_pkg::STEP_DELAY +: psc_pkg::STEP_DELAY_W] != '0) begin
                  next_s.fsm = FSM_WAIT;
               end else begin
                  next_s.step = s.step + 1'b1;
               end
            end
         end
         FSM_WAIT: begin
            // Slot timing comes from the slow RC clock, not mclk
            if (tick) begin
               next_s.wait_cnt = s.wait_cnt - 1'b1;
               if (s.wait_cnt == 4'h1) begin
                  next_s.step = s.step + 1'b1;
                  next_s.fsm = FSM_RUN;
               end
            end
         end
         default: next_s.fsm = FSM_IDLE;
      endcase

      // Output view: merges, pin gating and the zero-code switch-off
      for (int i = 0; i < NUM_RES; i++) begin
         next_s.on_out[i] = next_s.en[i]
            & (~otp_sleep_map_i[i] | s.slp_sync[1])
            & (~otp_en1_map_i[i] | s.en1_sync[1]);
         if (i < psc_pkg::NUM_SWITCHERS && next_s.vcode[i] == psc_pkg::VCODE_RST) begin
            next_s.on_out[i] = 1'b0;
         end
         next_s.vcode_out[i] = next_s.vcode[i];
      end
      // Partner phases follow the dual-phase master as one resource
      if (merge_a_i) begin
         next_s.on_out[psc_pkg::RES_SINGLE_PHASE_RAIL_A] =
            next_s.on_out[psc_pkg::RES_DUAL_PHASE_RAIL_A];
         next_s.vcode_out[psc_pkg::RES_SINGLE_PHASE_RAIL_A] =
            next_s.vcode[psc_pkg::RES_DUAL_PHASE_RAIL_A];
      end
      if (merge_b_i) begin
         next_s.on_out[psc_pkg::RES_SINGLE_PHASE_RAIL_B] =
            next_s.on_out[psc_pkg::RES_DUAL_PHASE_RAIL_B];
         next_s.vcode_out[psc_pkg::RES_SINGLE_PHASE_RAIL_B] =
            next_s.vcode[psc_pkg::RES_DUAL_PHASE_RAIL_B];
      end
   end

   // State register; reset clears all, BOOT then loads OTP defaults
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs
   assign rail_on_o = s.on_out;
   assign rail_vcode_o = s.vcode_out;
   assign ext_en_o = s.on_out[NUM_RES-1 -: 4];
   assign power_state_o = s.pstate;
   assign seq_busy_o = (s.fsm == FSM_RUN) || (s.fsm == FSM_WAIT);
   assign host_rd_en_o = s.en;
   assign host_rd_vcode_o = s.vcode;
endmodule
`default_nettype wire

// file: tb/psc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
   // Clock
   input wire logic mclk_i,
   // Host and scaling ports
   output logic host_wr_o,
   output logic [4:0] host_res_o,
   output logic host_en_o,
   output logic [7:0] host_vcode_o,
   output logic dvs_wr_o,
   output logic [1:0] dvs_sel_o,
   output logic [7:0] dvs_vcode_o
);
   // Idle ports at time zero
   initial begin
      {host_wr_o, host_res_o, host_en_o, host_vcode_o} = '0;
      {dvs_wr_o, dvs_sel_o, dvs_vcode_o} = '0;
   end
   // One strobe cycle; data inverted after so stale values never look valid
   task automatic wr(input logic [4:0] r, input logic e, input logic [7:0] v);
      @(negedge mclk_i);
      {host_wr_o, host_res_o, host_en_o, host_vcode_o} = {1'b1, r, e, v};
      @(negedge mclk_i);
      {host_wr_o, host_res_o, host_en_o, host_vcode_o} = {1'b0, ~r, ~e, ~v};
      @(negedge mclk_i);
   endtask
   // Scaling port write, same shape
   task automatic dvs(input logic [1:0] s, input logic [7:0] v);
      @(negedge mclk_i);
      {dvs_wr_o, dvs_sel_o, dvs_vcode_o} = {1'b1, s, v};
      @(negedge mclk_i);
      {dvs_wr_o, dvs_sel_o, dvs_vcode_o} = {1'b0, ~s, ~v};
      @(negedge mclk_i);
   endtask
endmodule
`default_nettype wire

// file: tb/psc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module psc_chk #(
   parameter int NUM_RES = 22
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Watched inputs
   input wire logic merge_a_i,
   input wire logic host_wr_i,
   input wire logic [4:0] host_res_i,
   input wire logic host_en_i,
   input wire logic dvs_wr_i,
   input wire logic [1:0] dvs_sel_i,
   input wire logic [7:0] dvs_vcode_i,
   // Watched outputs
   input wire logic [NUM_RES-1:0] rail_on_o,
   input wire logic [NUM_RES*8-1:0] rail_vcode_o,
   input wire logic [3:0] ext_en_o,
   input wire logic [1:0] power_state_o,
   input wire logic seq_busy_o,
   input wire logic [NUM_RES-1:0] host_rd_en_o,
   input wire logic [NUM_RES*8-1:0] host_rd_vcode_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Boot edge and a running sequence may both overwrite a host write
   a_host_en: assert property (host_wr_i && host_res_i < NUM_RES && !seq_busy_o
      && !$past(rst_i) |=> host_rd_en_o[$past(host_res_i)] == $past(host_en_i))
      else $error("host enable not stored");
   a_lin_clamp: assert property (host_wr_i && host_res_i >= 7
      && host_res_i < NUM_RES && !seq_busy_o && !$past(rst_i)
      |=> host_rd_vcode_o[$past(host_res_i)*8 +: 8] <= psc_pkg::LINEAR_CODE_MAX)
      else $error("linear code out of span");
   a_sw_zero: assert property (rail_vcode_o[7:0] == 8'h00 |-> !rail_on_o[0])
      else $error("zero code rail still on");
   // Pin gating may only take an external enable away, never add one
   a_ext_map: assert property (
      ext_en_o == rail_on_o[NUM_RES-1 -: 4]
      && (ext_en_o & ~host_rd_en_o[NUM_RES-1 -: 4]) == 4'h0)
      else $error("external enables differ from resources");
   a_state_code: assert property (power_state_o != 2'h3)
      else $error("illegal power state");
   a_state_busy: assert property ($changed(power_state_o) |-> $fell(seq_busy_o))
      else $error("state changed outside sequence end");
   a_merge_mirror: assert property (merge_a_i && $past(merge_a_i)
      && $stable(rail_vcode_o[7:0]) |=> rail_vcode_o[15:8] == rail_vcode_o[7:0])
      else $error("merged rail not mirrored");
   a_dvs_code: assert property (dvs_wr_i && dvs_sel_i == 2'h0
      && dvs_vcode_i[6:0] <= 7'h73 && !seq_busy_o && !$past(rst_i)
      |=> host_rd_vcode_o[7:0] == $past(dvs_vcode_i))
      else $error("scaling code not stored");
endmodule
bind psc_power_state_controller psc_chk #(.NUM_RES(NUM_RES)) chk_u (.mclk_i, .rst_i,
   .merge_a_i, .host_wr_i, .host_res_i, .host_en_i, .dvs_wr_i, .dvs_sel_i, .dvs_vcode_i,
   .rail_on_o, .rail_vcode_o, .ext_en_o, .power_state_o, .seq_busy_o, .host_rd_en_o,
   .host_rd_vcode_o);
`default_nettype wire

// file: tb/tb_psc_power_state_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_psc_power_state_controller;
   localparam int NR = 22;
   localparam int SW = psc_pkg::STEP_W;
   logic mclk_i = 1'b0, rst_i = 1'b1, osc = 1'b0, sl_n = 1'b1, en1 = 1'b1, rf = 1'b0, mrg = 1'b0;
   logic [3:0] req_i = 4'h0;
   logic [NR-1:0] def_en = 22'h00000F, slm = 22'h000002, e1m = 22'h000008, rfm = 22'h000010;
   logic [7:0] roof = 8'h40, flr = 8'h30;
   logic [NR*8-1:0] def_vc = {NR{8'h20}};
   logic [5*8*SW-1:0] seq = '0;
   logic host_wr_i, host_en_i, dvs_wr_i, seq_busy_o;
   logic [4:0] host_res_i;
   logic [7:0] host_vcode_i, dvs_vcode_i;
   logic [1:0] dvs_sel_i, power_state_o;
   logic [3:0] ext_en_o;
   logic [NR-1:0] rail_on_o, host_rd_en_o;
   logic [NR*8-1:0] rail_vcode_o, host_rd_vcode_o;
   int err_total = 0, num_checks = 0;
   psc_host_model host_u (.mclk_i, .host_wr_o(host_wr_i), .host_res_o(host_res_i),
      .host_en_o(host_en_i), .host_vcode_o(host_vcode_i), .dvs_wr_o(dvs_wr_i),
      .dvs_sel_o(dvs_sel_i), .dvs_vcode_o(dvs_vcode_i));
   psc_power_state_controller #(.NUM_RES(NR), .STEPS(8)) dut_u (.mclk_i, .rst_i, .req_i,
      .osc32k_i(osc), .sleep_request_pin_n_i(sl_n), .first_enable_pin_i(en1),
      .roof_floor_i(rf), .otp_def_en_i(def_en), .otp_def_vcode_i(def_vc), .otp_seq_i(seq),
      .otp_sleep_map_i(slm), .otp_en1_map_i(e1m), .otp_rf_map_i(rfm), .merge_a_i(mrg),
      .merge_b_i(mrg), .host_wr_i, .host_res_i, .host_en_i, .host_vcode_i,
      .roof_vcode_i(roof), .floor_vcode_i(flr), .dvs_wr_i, .dvs_sel_i, .dvs_vcode_i,
      .rail_on_o, .rail_vcode_o, .ext_en_o, .power_state_o, .seq_busy_o, .host_rd_en_o,
      .host_rd_vcode_o);
   // 100 MHz system clock and free running 32-kHz oscillator
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   initial begin
      forever #15625 osc = ~osc;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   function automatic logic [SW-1:0] stp(input logic [4:0] r, input logic e,
      input logic [7:0] v, input logic [3:0] d);
      return {d, v, e, r, 1'b1};
   endfunction
   // Release reset; pin syncs clear 0 and settle by the third edge
   task automatic t_boot();
      repeat (8) @(negedge mclk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge mclk_i);
      chk("boot en", def_en, rail_on_o);
      chk("boot code", 8'h20, rail_vcode_o[79:72]);
   endtask
   // Pins are synchronised, so a few cycles pass before checking
   task automatic t_pins();
      sl_n = 1'b0;
      repeat (8) @(negedge mclk_i);
      chk("sleep gate", 1'b0, rail_on_o[1]);
      en1 = 1'b0;
      repeat (8) @(negedge mclk_i);
      chk("en1 gate", 1'b0, rail_on_o[3]);
      {sl_n, en1} = 2'h3;
      repeat (8) @(negedge mclk_i);
      chk("gate release", 4'hF, rail_on_o[3:0]);
   endtask
   task automatic t_regs();
      host_u.wr(5'h07, 1'b1, 8'h3F);
      chk("lin clamp", 8'h31, host_rd_vcode_o[63:56]);
      host_u.wr(5'h02, 1'b1, 8'hFF);
      chk("sw clamp", 8'hF3, host_rd_vcode_o[23:16]);
      host_u.wr(5'h00, 1'b1, 8'h00);
      chk("zero off", 1'b0, rail_on_o[0]);
      host_u.wr(5'h19, 1'b0, 8'h00);
      chk("refused res", 22'h00008F, host_rd_en_o);
      mrg = 1'b1;
      host_u.wr(5'h00, 1'b1, 8'h22);
      chk("merge", 8'h22, rail_vcode_o[15:8]);
      mrg = 1'b0;
      host_u.dvs(2'h0, 8'h12);
      chk("dvs", 8'h12, rail_vcode_o[7:0]);
      rf = 1'b1;
      repeat (8) @(negedge mclk_i);
      chk("roof", 8'h40, rail_vcode_o[39:32]);
      rf = 1'b0;
      repeat (8) @(negedge mclk_i);
      chk("floor", 8'h30, rail_vcode_o[39:32]);
   endtask
   // Step i of the state walk; request bit and expectations packed per step
   task automatic t_req(input int i);
      int n;
      int b;
      b = (16'h47B2 >> (2*i)) & 3;
      n = 0;
      req_i[b] = 1'b1;
      while (seq_busy_o !== 1'b1 && n < 20) begin
         @(negedge mclk_i);
         n++;
      end
      req_i[b] = 1'b0;
      n = 0;
      // A delayed step may wait up to one full oscillator period
      while (seq_busy_o === 1'b1 && n < 5000) begin
         @(negedge mclk_i);
         n++;
      end
      @(negedge mclk_i);
      chk("busy end", 1'b0, seq_busy_o);
      chk("state", (16'h1264 >> (2*i)) & 3, power_state_o);
      chk("res8 on", (8'hC2 >> i) & 1, rail_on_o[8]);
      chk("ext0", (8'h5E >> i) & 1, ext_en_o[0]);
      chk("tick wait", (8'h42 >> i) & 1, n > 1000);
   endtask
   // Resource 8 keeps its sequence code; resource 9, which nothing writes, keeps its defaults
   task automatic t_kept();
      chk("seq code", 8'h10, rail_vcode_o[71:64]);
      chk("kept code", 8'h20, rail_vcode_o[79:72]);
      chk("kept en", 1'b0, rail_on_o[9]);
   endtask
   initial begin
      seq[0 +: SW] = stp(5'h08, 1'b1, 8'h10, 4'h1);
      seq[SW +: SW] = stp(5'h12, 1'b1, 8'h01, 4'h0);
      seq[8*SW +: SW] = stp(5'h12, 1'b0, 8'h01, 4'h0);
      seq[16*SW +: SW] = stp(5'h12, 1'b0, 8'h01, 4'h0);
      seq[24*SW +: SW] = stp(5'h08, 1'b0, 8'h10, 4'h0);
      t_boot();
      t_pins();
      t_regs();
      // Refused wake, then on, sleep, wake, sleep, off, on, off
      for (int i = 0; i < 8; i++) begin
         t_req(i);
      end
      t_kept();
      wrap_up();
   end
   // Watchdog about four times the expected run of two slow sequences
   initial begin
      #200000;
      err_total++;
      wrap_up();
   end
endmodule
`default_nettype wire
